// ===== hw/bsr_data_regs.sv
/*
 * Boundary-scan test data registers with instruction register and
 * pin multiplexing. Assumes an outside test controller supplies the
 * capture/shift/update strobes, capture and update one cycle each, on clk (test clock).
 */
`timescale 1ns/1ns
module bsr_data_regs
    import bsr_pkg::*;
#(
    parameter int CHAIN_LEN = BSR_LEN
) (
    // clock and test reset
    input  wire logic        clk,
    input  wire logic        rst,
    // test controller strobes and serial data
    input  wire logic        tdi,
    input  wire logic        captureDr,
    input  wire logic        shiftDr,
    input  wire logic        updateDr,
    input  wire logic        captureIr,
    input  wire logic        shiftIr,
    input  wire logic        updateIr,
    output logic             tdo,
    output logic             tdoOe,
    // core side drive values
    input  wire logic [15:0] coreStreamOut,
    input  wire logic [15:0] coreStreamOe,
    input  wire logic        coreCtrlStreamOut,
    input  wire logic        coreCtrlStreamOe,
    input  wire logic        coreAckOut,
    input  wire logic [15:0] coreDataOut,
    input  wire logic [15:0] coreDataOe,
    // pin inputs
    input  wire logic [15:0] dataPinIn,
    input  wire logic        outputDriveEnableIn,
    input  wire logic        busInterfaceSelect,
    input  wire logic        addressStrobeLatch,
    input  wire logic        chipSelect,
    input  wire logic        readWrite,
    input  wire logic        dataStrobeRead,
    input  wire logic [7:0]  addressIn,
    input  wire logic        wideFramePulseSelect,
    input  wire logic        resetPin,
    input  wire logic        clockPin,
    input  wire logic        frameMeasureIn,
    input  wire logic        framePulseIn,
    input  wire logic [15:0] serialInStream,
    // pin outputs
    output logic [15:0]      serialOutStream,
    output logic [15:0]      serialOutStreamOe,
    output logic             controlStreamOut,
    output logic             controlStreamOutOe,
    output logic             transferAcknowledgeOut,
    output logic [15:0]      muxedAddrDataBit,
    output logic [15:0]      muxedAddrDataBitOe
);

    if (CHAIN_LEN != BSR_LEN) begin : g_len_check
        $error("chain length must match the cell map");
    end

    logic [BSR_LEN-1:0]  capVec;
    logic [BSR_LEN-1:0]  chainQ;
    logic [BSR_LEN-1:0]  updQ;
    logic [BSR_IR_W-1:0] irShift_r;
    bsr_instr_type       instr_r;
    logic                bypass_r;
    logic                bsrSel;
    logic                isExtest;
    logic                serialOut;
    logic [15:0]         extSos;
    logic [15:0]         extSosOe;

    assign bsrSel   = (instr_r == BSR_EXTEST) || (instr_r == BSR_SAMPLE);
    assign isExtest = (instr_r == BSR_EXTEST);

    // capture map; control and output cells sample the core
    genvar k;
    for (k = 0; k < 16; k++) begin : g_map
        if (k < 8) begin : g_lo
            assign capVec[BSR_SOS_LO_BASE + 2*(7-k)]     = coreStreamOe[k];
            assign capVec[BSR_SOS_LO_BASE + 2*(7-k) + 1] = coreStreamOut[k];
            assign capVec[BSR_ADDR_BASE + 7 - k]         = addressIn[k];
            assign extSos[k]   = updQ[BSR_SOS_LO_BASE + 2*(7-k) + 1];
            assign extSosOe[k] = updQ[BSR_SOS_LO_BASE + 2*(7-k)];
        end else begin : g_hi
            assign capVec[BSR_SOS_HI_BASE + 2*(15-k)]     = coreStreamOe[k];
            assign capVec[BSR_SOS_HI_BASE + 2*(15-k) + 1] = coreStreamOut[k];
            assign extSos[k]   = updQ[BSR_SOS_HI_BASE + 2*(15-k) + 1];
            assign extSosOe[k] = updQ[BSR_SOS_HI_BASE + 2*(15-k)];
        end
        assign capVec[BSR_DATA_BASE + 3*(15-k)]     = coreDataOe[k];
        assign capVec[BSR_DATA_BASE + 3*(15-k) + 1] = coreDataOut[k];
        assign capVec[BSR_DATA_BASE + 3*(15-k) + 2] = dataPinIn[k];
        assign capVec[BSR_SIS_BASE + 15 - k]        = serialInStream[k];
    end
    assign capVec[BSR_ODE_CELL]    = outputDriveEnableIn;
    assign capVec[BSR_CSO_CTRL]    = coreCtrlStreamOe;
    assign capVec[BSR_CSO_DATA]    = coreCtrlStreamOut;
    assign capVec[BSR_ACK_CELL]    = coreAckOut;
    assign capVec[BSR_BUSSEL_CELL] = busInterfaceSelect;
    assign capVec[BSR_ASTB_CELL]   = addressStrobeLatch;
    assign capVec[BSR_CSEL_CELL]   = chipSelect;
    assign capVec[BSR_RDWR_CELL]   = readWrite;
    assign capVec[BSR_DSTB_CELL]   = dataStrobeRead;
    assign capVec[BSR_WIDE_FRAME_PULSE_SELECT_CELL]   = wideFramePulseSelect;
    assign capVec[BSR_RESET_CELL]  = resetPin;
    assign capVec[BSR_CLK_CELL]    = clockPin;
    assign capVec[BSR_FMEAS_CELL]  = frameMeasureIn;
    assign capVec[BSR_FPULSE_CELL] = framePulseIn;

    // one serial path; tdi enters at the top, cell 0 nearest tdo
    genvar c;
    for (c = 0; c < BSR_LEN; c++) begin : g_cell
        bsr_scan_cell u_cell (
            .clk        (clk),
            .rst        (rst),
            .captureEn  (captureDr && bsrSel),
            .shiftEn    (shiftDr && bsrSel),
            .updateEn   (updateDr && bsrSel),
            .captureVal (capVec[c]),
            .serialIn   ((c == BSR_LEN-1) ? tdi : chainQ[(c+1) % BSR_LEN]),
            .shiftQ     (chainQ[c]),
            .updateQ    (updQ[c])
        );
    end

    // bypass: single stage, captures zero as usual
    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_r <= 1'b0;
        end else if (captureDr && !bsrSel) begin
            bypass_r <= 1'b0;
        end else if (shiftDr && !bsrSel) begin
            bypass_r <= tdi;
        end
    end

    // instruction shifter, lsb leaves first
    always_ff @(posedge clk) begin
        if (rst) begin
            irShift_r <= BSR_IR_RESET;
        end else if (captureIr) begin
            irShift_r <= BSR_IR_CAPTURE;
        end else if (shiftIr) begin
            irShift_r <= {tdi, irShift_r[BSR_IR_W-1]};
        end
    end

    // reset lands in bypass so pins stay with the core
    always_ff @(posedge clk) begin
        if (rst) begin
            instr_r <= BSR_BYPASS;
        end else if (updateIr) begin
            instr_r <= bsr_instr_type'(irShift_r);
        end
    end

    always_comb begin
        if (shiftIr) begin
            serialOut = irShift_r[0];
        end else if (bsrSel) begin
            serialOut = chainQ[0];
        end else begin
            serialOut = bypass_r;
        end
    end

    // falling edge launch gives the controller half a period of setup
    always_ff @(negedge clk) begin
        if (rst) begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0;
        end else begin
            tdo   <= serialOut;
            tdoOe <= shiftDr || shiftIr;
        end
    end

    // pin drive; registered so outputs come from flops (one cycle lag)
    // stream cell picks sit in the map loop so no index leaves the chain
    always_ff @(posedge clk) begin
        if (rst) begin
            serialOutStream   <= 16'h0000;
            serialOutStreamOe <= 16'h0000;
        end else if (isExtest) begin
            serialOutStream   <= extSos;
            serialOutStreamOe <= extSosOe;
        end else begin
            serialOutStream   <= coreStreamOut;
            serialOutStreamOe <= coreStreamOe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            muxedAddrDataBit   <= 16'h0000;
            muxedAddrDataBitOe <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (isExtest) begin
                    muxedAddrDataBit[i]   <= updQ[BSR_DATA_BASE + 3*(15-i) + 1];
                    muxedAddrDataBitOe[i] <= updQ[BSR_DATA_BASE + 3*(15-i)];
                end else begin
                    muxedAddrDataBit[i]   <= coreDataOut[i];
                    muxedAddrDataBitOe[i] <= coreDataOe[i];
                end
            end
        end
    end

    // acknowledge has no control cell; its driver stays on
    always_ff @(posedge clk) begin
        if (rst) begin
            controlStreamOut       <= 1'b0;
            controlStreamOutOe     <= 1'b0;
            transferAcknowledgeOut <= 1'b0;
        end else if (isExtest) begin
            controlStreamOut       <= updQ[BSR_CSO_DATA];
            controlStreamOutOe     <= updQ[BSR_CSO_CTRL];
            transferAcknowledgeOut <= updQ[BSR_ACK_CELL];
        end else begin
            controlStreamOut       <= coreCtrlStreamOut;
            controlStreamOutOe     <= coreCtrlStreamOe;
            transferAcknowledgeOut <= coreAckOut;
        end
    end

    a_bypass_one_bit: assert property (@(posedge clk) disable iff (rst)
        shiftDr && !bsrSel |=> bypass_r == $past(tdi))
        else $error("bypass did not take tdi");
    a_chain_entry: assert property (@(posedge clk) disable iff (rst)
        shiftDr && bsrSel ##1 shiftDr && bsrSel |=> chainQ[116] == $past(tdi, 2))
        else $error("chain top not shifting down");
    a_tdo_cell0: assert property (@(posedge clk) disable iff (rst)
        shiftDr && bsrSel && !$past(rst) |-> tdo == chainQ[0])
        else $error("tdo not from cell 0");
    a_tdo_float: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> tdoOe == (shiftDr || shiftIr))
        else $error("tdo enable wrong");
    a_ir_load: assert property (@(posedge clk) disable iff (rst)
        shiftIr ##1 updateIr |=> instr_r == $past(irShift_r))
        else $error("instruction not loaded");
    a_extest_oe: assert property (@(posedge clk) disable iff (rst)
        isExtest |=> serialOutStreamOe[0] == $past(updQ[14]))
        else $error("stream 0 enable not from cell 14");
    a_hi_stream: assert property (@(posedge clk) disable iff (rst)
        isExtest |=> serialOutStream[8] == $past(updQ[117]))
        else $error("stream 8 data not from cell 117");
    a_data_pass: assert property (@(posedge clk) disable iff (rst)
        !isExtest |=> muxedAddrDataBit[15] == $past(coreDataOut[15]))
        else $error("data pin not following core");
    a_ode_capture: assert property (@(posedge clk) disable iff (rst)
        captureDr && bsrSel |=> chainQ[16] == $past(outputDriveEnableIn))
        else $error("drive-enable cell capture wrong");
    a_frame_capture: assert property (@(posedge clk) disable iff (rst)
        captureDr && bsrSel |=> chainQ[85] == $past(framePulseIn))
        else $error("frame pulse cell capture wrong");
    a_select_path: assert property (@(posedge clk) disable iff (rst)
        shiftDr && !bsrSel |=> $stable(chainQ))
        else $error("chain moved while bypassed");

    c_extest: cover property (@(posedge clk) updateIr ##1 isExtest);
    c_bsr_scan: cover property (@(posedge clk)
        captureDr && bsrSel ##1 (shiftDr && bsrSel) [*8]);
    c_bypass_scan: cover property (@(posedge clk)
        shiftDr && !bsrSel ##1 shiftDr);

endmodule

// ===== hw/bsr_pkg.sv
/*
 * Constants for the boundary-scan test data registers: chain length,
 * cell positions of every scanned pin, instruction codes.
 * Assumes the importing logic shifts toward cell 0 (cell 0 leaves first).
 */
package bsr_pkg;

    localparam int BSR_LEN         = 118;
    localparam int BSR_IR_W        = 2;

    // serial output streams 7..0, pairs of control then data
    localparam int BSR_SOS_LO_BASE = 0;
    localparam int BSR_ODE_CELL    = 16;
    localparam int BSR_CSO_CTRL    = 17;
    localparam int BSR_CSO_DATA    = 18;
    localparam int BSR_ACK_CELL    = 19;
    // data pins 15..8 then muxed address/data 7..0, three cells each
    localparam int BSR_DATA_BASE   = 20;
    localparam int BSR_BUSSEL_CELL = 68;
    localparam int BSR_ASTB_CELL   = 69;
    localparam int BSR_CSEL_CELL   = 70;
    localparam int BSR_RDWR_CELL   = 71;
    localparam int BSR_DSTB_CELL   = 72;
    localparam int BSR_ADDR_BASE   = 73;
    localparam int BSR_WIDE_FRAME_PULSE_SELECT_CELL   = 81;
    localparam int BSR_RESET_CELL  = 82;
    localparam int BSR_CLK_CELL    = 83;
    localparam int BSR_FMEAS_CELL  = 84;
    localparam int BSR_FPULSE_CELL = 85;
    localparam int BSR_SIS_BASE    = 86;
    // serial output streams 15..8
    localparam int BSR_SOS_HI_BASE = 102;

    // value loaded into the instruction shifter on capture
    localparam logic [1:0] BSR_IR_CAPTURE = 2'h1;
    localparam logic [1:0] BSR_IR_RESET   = 2'h3;

    typedef enum logic [1:0] {
        BSR_EXTEST = 2'h0,
        BSR_SAMPLE = 2'h1,
        BSR_BYP_A  = 2'h2,
        BSR_BYPASS = 2'h3
    } bsr_instr_type;

endpackage

// ===== hw/bsr_scan_cell.sv
/*
 * One boundary-scan cell: a shift stage and an update latch.
 * Assumes capture, shift and update enables are mutually exclusive.
 */
`timescale 1ns/1ns
module bsr_scan_cell (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // controls
    input  wire logic captureEn,
    input  wire logic shiftEn,
    input  wire logic updateEn,
    // data
    input  wire logic captureVal,
    input  wire logic serialIn,
    output logic      shiftQ,
    output logic      updateQ
);

    always_ff @(posedge clk) begin
        if (rst) begin
            shiftQ <= 1'b0;
        end else if (captureEn) begin
            shiftQ <= captureVal;
        end else if (shiftEn) begin
            shiftQ <= serialIn;
        end
    end

    // update stage holds still while shifting, so pins do not ripple
    always_ff @(posedge clk) begin
        if (rst) begin
            updateQ <= 1'b0;
        end else if (updateEn) begin
            updateQ <= shiftQ;
        end
    end

endmodule

// ===== testbench/bsr_test_ctrl.sv
/*
 * Behavioural boundary-scan test controller: drives the state strobes
 * and serial data toward the test data registers.
 * Assumes one caller, entering its tasks just after a rising clk edge.
 */
`timescale 1ns/1ns
module bsr_test_ctrl (
    // clock
    input  wire logic clk,
    // strobes and serial data
    output logic      tdi,
    output logic      captureDr,
    output logic      shiftDr,
    output logic      updateDr,
    output logic      captureIr,
    output logic      shiftIr,
    output logic      updateIr
);
    initial begin
        {tdi, captureDr, shiftDr, updateDr} = 4'h0;
        {captureIr, shiftIr, updateIr} = 3'h0;
    end
    // changes land just after an edge, so the next edge samples them
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // two-bit instruction, lsb first
    task automatic irLoad(input logic [1:0] code);
        captureIr = 1'b1;
        tick();
        captureIr = 1'b0;
        shiftIr = 1'b1;
        tdi = code[0];
        tick();
        tdi = code[1];
        tick();
        shiftIr = 1'b0;
        updateIr = 1'b1;
        tdi = ~tdi;
        tick();
        updateIr = 1'b0;
    endtask
    // released data line shows the inverse, not a stale copy
    task automatic drScan(input int n, input logic [117:0] v);
        captureDr = 1'b1;
        tick();
        captureDr = 1'b0;
        shiftDr = 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi = v[i];
            tick();
        end
        shiftDr = 1'b0;
        updateDr = 1'b1;
        tdi = ~tdi;
        tick();
        updateDr = 1'b0;
    endtask
endmodule

// ===== testbench/tb_bsr_data_regs.sv
/*
 * Self-checking bench for the boundary-scan data registers.
 * Assumes the controller model drives all strobes; tdo checked by queue.
 */
`timescale 1ns/1ns
module tb_bsr_data_regs
    import bsr_pkg::*;
();
    logic clk, rst, tdi, tdo, tdoOe, captureDr, shiftDr, updateDr;
    logic captureIr, shiftIr, updateIr, coreCtrlStreamOut;
    logic coreCtrlStreamOe, coreAckOut, outputDriveEnableIn;
    logic busInterfaceSelect, addressStrobeLatch, chipSelect, readWrite;
    logic dataStrobeRead, wideFramePulseSelect, resetPin, clockPin;
    logic frameMeasureIn, framePulseIn, controlStreamOut;
    logic controlStreamOutOe, transferAcknowledgeOut;
    logic [15:0] coreStreamOut, coreStreamOe, coreDataOut, coreDataOe;
    logic [15:0] dataPinIn, serialInStream, serialOutStream;
    logic [15:0] serialOutStreamOe, muxedAddrDataBit, muxedAddrDataBitOe;
    logic [7:0]  addressIn;
    logic [117:0] p;
    logic [127:0] r;
    logic        expQ[$];
    int          seed = 40080;
    int          numErrors = 0;
    int          nCompared = 0;

    bsr_data_regs #(.CHAIN_LEN(BSR_LEN)) u_bsr_data_regs (
        .clk, .rst, .tdi, .captureDr, .shiftDr, .updateDr, .captureIr,
        .shiftIr, .updateIr, .tdo, .tdoOe, .coreStreamOut, .coreStreamOe,
        .coreCtrlStreamOut, .coreCtrlStreamOe, .coreAckOut, .coreDataOut,
        .coreDataOe, .dataPinIn, .outputDriveEnableIn, .busInterfaceSelect,
        .addressStrobeLatch, .chipSelect, .readWrite, .dataStrobeRead,
        .addressIn, .wideFramePulseSelect, .resetPin, .clockPin,
        .frameMeasureIn, .framePulseIn, .serialInStream, .serialOutStream,
        .serialOutStreamOe, .controlStreamOut, .controlStreamOutOe,
        .transferAcknowledgeOut, .muxedAddrDataBit, .muxedAddrDataBitOe);
    bsr_test_ctrl u_bsr_test_ctrl (
        .clk, .tdi, .captureDr, .shiftDr, .updateDr, .captureIr, .shiftIr,
        .updateIr);

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic endSim();
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // empty queue gives x, so an extra shifted bit never matches
    always @(posedge clk) begin
        logic e;
        if (tdoOe === 1'b1) begin
            e = 1'bx;
            if (expQ.size() > 0)
                e = expQ.pop_front();
            chk("tdo", {15'h0, e}, {15'h0, tdo});
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        endSim();
    end
    task automatic shake();
        {coreStreamOut, coreStreamOe} = $random(seed);
        {coreDataOut, coreDataOe} = $random(seed);
        {dataPinIn, serialInStream} = $random(seed);
        r[31:0] = $random(seed);
        {addressIn, coreCtrlStreamOut, coreCtrlStreamOe, coreAckOut} =
            r[10:0];
        {outputDriveEnableIn, busInterfaceSelect, addressStrobeLatch,
         chipSelect, readWrite, dataStrobeRead, wideFramePulseSelect,
         resetPin, clockPin, frameMeasureIn, framePulseIn} = r[21:11];
    endtask
    function automatic logic [117:0] cap();
        logic [117:0] v;
        v = '0;
        for (int i = 0; i < 8; i++) begin
            v[2*i+1] = coreStreamOut[7-i];
            v[2*i] = coreStreamOe[7-i];
            v[103+2*i] = coreStreamOut[15-i];
            v[102+2*i] = coreStreamOe[15-i];
            v[80-i] = addressIn[i];
        end
        for (int k = 0; k < 16; k++) begin
            v[20+3*k] = coreDataOe[15-k];
            v[21+3*k] = coreDataOut[15-k];
            v[22+3*k] = dataPinIn[15-k];
            v[101-k] = serialInStream[k];
        end
        v[19:16] = {coreAckOut, coreCtrlStreamOut, coreCtrlStreamOe,
                    outputDriveEnableIn};
        v[72:68] = {dataStrobeRead, readWrite, chipSelect,
                    addressStrobeLatch, busInterfaceSelect};
        v[85:81] = {framePulseIn, frameMeasureIn, clockPin, resetPin,
                    wideFramePulseSelect};
        return v;
    endfunction
    task automatic pins(input logic ext, input logic [117:0] q);
        logic [15:0] s, so, m, mo;
        logic [2:0]  c;
        s = coreStreamOut;
        so = coreStreamOe;
        m = coreDataOut;
        mo = coreDataOe;
        c = {coreCtrlStreamOe, coreCtrlStreamOut, coreAckOut};
        if (ext) begin
            for (int i = 0; i < 8; i++) begin
                {s[7-i], so[7-i]} = q[2*i+:2];
                {s[15-i], so[15-i]} = q[102+2*i+:2];
            end
            for (int k = 0; k < 16; k++)
                {m[15-k], mo[15-k]} = q[20+3*k+:2];
            c = {q[17], q[18], q[19]};
        end
        chk("stream", s, serialOutStream);
        chk("streamOe", so, serialOutStreamOe);
        chk("muxed", m, muxedAddrDataBit);
        chk("muxedOe", mo, muxedAddrDataBitOe);
        chk("ctrl", {13'h0, c}, {13'h0, controlStreamOutOe,
            controlStreamOut, transferAcknowledgeOut});
        chk("tdoOe", 16'h0, {15'h0, tdoOe});
    endtask
    task automatic ir(input logic [1:0] c);
        expQ.push_back(1'b1);
        expQ.push_back(1'b0);
        u_bsr_test_ctrl.irLoad(c);
    endtask
    task automatic dr(input int n, input logic [117:0] v,
                      input logic [117:0] ex);
        for (int i = 0; i < n; i++)
            expQ.push_back(ex[i]);
        u_bsr_test_ctrl.drScan(n, v);
        repeat (3) u_bsr_test_ctrl.tick();
    endtask

    initial begin
        rst = 1'b1;
        shake();
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        u_bsr_test_ctrl.tick();
        dr(1, 118'h1, 118'h0);
        dr(1, 118'h1, 118'h0);
        pins(1'b0, 118'h0);
        $display("test reset_bypass done");
        for (int t = 0; t < 4; t++) begin
            shake();
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            p = r[117:0];
            repeat (3) u_bsr_test_ctrl.tick();
            ir(BSR_SAMPLE);
            dr(BSR_LEN, p, cap());
            pins(1'b0, p);
            ir(BSR_EXTEST);
            repeat (3) u_bsr_test_ctrl.tick();
            pins(1'b1, p);
            ir(t[0] ? BSR_BYPASS : BSR_BYP_A);
            dr(2, 118'h1, 118'h2);
            pins(1'b0, p);
        end
        $display("test sample_extest done");
        ir(BSR_EXTEST);
        repeat (3) u_bsr_test_ctrl.tick();
        rst = 1'b1;
        repeat (2) u_bsr_test_ctrl.tick();
        chk("rstPins", 16'h0, serialOutStream | serialOutStreamOe |
            muxedAddrDataBit | muxedAddrDataBitOe);
        rst = 1'b0;
        repeat (3) u_bsr_test_ctrl.tick();
        pins(1'b0, 118'h0);
        ir(BSR_EXTEST);
        repeat (3) u_bsr_test_ctrl.tick();
        pins(1'b1, 118'h0);
        $display("test midrun_reset done");
        chk("queueLeft", 16'h0, 16'(expQ.size()));
        endSim();
    end
endmodule
